// ---- rtl/l1ho_ctrl.v ----
// input-loop reference switching, holdover state machine and registers
//
// Operation
// - count each cycle whose phase error stays below the lock threshold
// - any cycle with large phase error clears the count to zero
// - at the limit assert lock and freeze the count until an error
// - lock needs two to the power N consecutive low-error cycles
// - one bit selects manual or automatic reference switching
// - in manual mode a two-bit field picks the active reference
// - in manual mode a force bit governs holdover entry
// - automatic mode decides from loss flags, phase error, lock, settings
// - status always readable; evasive actions only in automatic mode
// - state stays in initialisation while reset is asserted
// - preload picks best reference (manual field in manual mode), acquisition starts the next cycle
// - lock moves the machine from acquisition to locked
// - in automatic mode locked enters holdover on lock loss, signal loss or priority switch
// - holdover tri-states the charge pump and optionally forces the DAC
// - leave holdover only with a stable reference and exit conditions met
// - holdover split into entry, steady and exit sub-states
// - the current state is readable as a three-bit code
// - everything runs on the common multiple clock
// - automatic switching only in preload or during holdover
// - exit criteria and exit action fields steer holdover exit
`timescale 1ns/1ns
`default_nettype none
`include "l1ho_defines.vh"

module l1ho_ctrl #(
  parameter CNT_W   = 32,
  parameter NUM_REF = 4
) (
  input  wire               clk_sys,             // common multiple clock
  input  wire               arst_n,              // async reset, active low
  input  wire               reg_wr,              // register write strobe
  input  wire               reg_rd,              // register read strobe
  input  wire [15:0]        reg_addr,            // register address
  input  wire [7:0]         reg_wdata,           // register write data
  output reg  [7:0]         reg_rdata_r,         // read data, next cycle
  input  wire [NUM_REF-1:0] signal_loss_flag,    // per-reference loss
  input  wire               phase_err_low,       // phase error below ~4 ns
  output reg                lock_detect_r,       // loop locked
  output reg  [1:0]         active_ref_r,        // reference in use
  output reg                charge_pump_tri_r,   // charge pump tri-stated
  output reg                dac_force_r,         // holdover DAC forcing
  output reg                div_reset_r,         // reset reference/feedback dividers
  output reg  [2:0]         loop1_state_code_r   // state code
);

  // ****************************************
  // state codes
  // ****************************************
  localparam [2:0] ST_INIT     = 3'h0;
  localparam [2:0] ST_PRELOAD  = 3'h1;
  localparam [2:0] ST_ACQUIRE  = 3'h2;
  localparam [2:0] ST_LOCKED   = 3'h3;
  localparam [2:0] ST_HO_ENTRY = 3'h4;
  localparam [2:0] ST_HO_HOLD  = 3'h5;
  localparam [2:0] ST_HO_EXIT  = 3'h6;

  // exit criteria and action codes
  localparam [1:0] CRIT_PHASE  = 2'h1;
  localparam [1:0] ACT_NO_RST  = 2'h1;
  localparam [1:0] ACT_DAC     = 2'h3;

  // ****************************************
  // configuration registers
  // ****************************************
  reg  [7:0] lock_timer_r;
  reg  [7:0] ref_select_r;
  reg  [7:0] exit_cfg_r;
  reg  [7:0] priority_r;
  reg  [7:0] ref_enable_r;

  wire [4:0] loop1_lock_count_exponent;
  wire [1:0] manual_ref;
  wire       use_dac;
  wire       automode;
  wire       force_ho;
  wire [1:0] exit_crit;
  wire [1:0] exit_act;

  assign loop1_lock_count_exponent = lock_timer_r[4:0];
  assign manual_ref = ref_select_r[`L1HO_SEL_MANUAL_LSB +: 2];
  assign use_dac    = ref_select_r[`L1HO_SEL_USE_DAC];
  assign automode   = ref_select_r[`L1HO_SEL_AUTOMODE];
  assign force_ho   = ref_select_r[`L1HO_SEL_FORCE_HO];
  assign exit_crit  = exit_cfg_r[`L1HO_EXIT_CRIT_LSB +: 2];
  assign exit_act   = exit_cfg_r[`L1HO_EXIT_ACT_LSB +: 2];

  // software writes; reads of unmapped addresses return zero
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lock_timer_r <= `L1HO_RST_LOCK_TIMER;
      ref_select_r <= `L1HO_RST_REF_SELECT;
      exit_cfg_r   <= `L1HO_RST_EXIT_CFG;
      priority_r   <= `L1HO_RST_PRIORITY;
      ref_enable_r <= `L1HO_RST_REF_ENABLE;
    end else if (reg_wr) begin
      if (reg_addr == `L1HO_OFS_LOCK_TIMER) begin
        lock_timer_r <= {3'h0, reg_wdata[4:0]};
      end else if (reg_addr == `L1HO_OFS_REF_SELECT) begin
        ref_select_r <= {3'h0, reg_wdata[4:0]};
      end else if (reg_addr == `L1HO_OFS_EXIT_CFG) begin
        exit_cfg_r <= {4'h0, reg_wdata[3:0]};
      end else if (reg_addr == `L1HO_OFS_PRIORITY) begin
        priority_r <= reg_wdata;
      end else if (reg_addr == `L1HO_OFS_REF_ENABLE) begin
        ref_enable_r <= {4'h0, reg_wdata[3:0]};
      end
    end
  end

  // ****************************************
  // status read-back
  // ****************************************
  reg [7:0] status_word;
  reg [7:0] rdata_nxt;

  // status fields are live in either mode
  always @* begin
    status_word = 8'h00;
    status_word[2:0] = loop1_state_code_r;
    status_word[`L1HO_ST_LOCK] = lock_detect_r;
    status_word[`L1HO_ST_REF_LSB +: 2] = active_ref_r;
    status_word[`L1HO_ST_HOLDOVER] = charge_pump_tri_r;
  end

  // address decode for the read path
  always @* begin
    rdata_nxt = 8'h00;
    if (reg_addr == `L1HO_OFS_LOCK_TIMER) begin
      rdata_nxt = lock_timer_r;
    end else if (reg_addr == `L1HO_OFS_REF_SELECT) begin
      rdata_nxt = ref_select_r;
    end else if (reg_addr == `L1HO_OFS_EXIT_CFG) begin
      rdata_nxt = exit_cfg_r;
    end else if (reg_addr == `L1HO_OFS_PRIORITY) begin
      rdata_nxt = priority_r;
    end else if (reg_addr == `L1HO_OFS_REF_ENABLE) begin
      rdata_nxt = ref_enable_r;
    end else if (reg_addr == `L1HO_OFS_STATE) begin
      rdata_nxt = status_word;
    end
  end

  // read data held until the next read
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // best reference from the priority table
  // ****************************************
  wire [NUM_REF-1:0] ref_ok;
  reg  [1:0]         best_ref;
  reg                best_ok;
  reg  [1:0]         cand;
  integer            i;

  genvar g;
  generate
    for (g = 0; g < NUM_REF; g = g + 1) begin : g_ok
      // a reference qualifies when enabled and free of signal loss
      assign ref_ok[g] = ref_enable_r[g] & ~signal_loss_flag[g];
    end
  endgenerate

  // first qualifying entry wins, highest priority in the low slot
  always @* begin
    best_ref = 2'h0;
    best_ok  = 1'b0;
    cand     = 2'h0;
    for (i = NUM_REF - 1; i >= 0; i = i - 1) begin
      cand = priority_r[2*i +: 2];
      if (ref_ok[cand]) begin
        best_ref = cand;
        best_ok  = 1'b1;
      end
    end
  end

  // a better reference than the active one has become usable
  wire prio_clash;
  assign prio_clash = best_ok && (best_ref != active_ref_r);

  // ****************************************
  // lock detect
  // ****************************************
  wire lock_raw;
  reg  ld_restart;

  l1ho_lock_detect #(
    .CNT_W    (CNT_W)
  ) u_lock (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .restart  (ld_restart),
    .err_low  (phase_err_low),
    .exponent (loop1_lock_count_exponent),
    .lock_r   (lock_raw)
  );

  // ****************************************
  // state machine
  // ****************************************
  reg  [2:0] state_nxt;
  reg  [1:0] ref_nxt;
  reg        div_nxt;
  reg  [1:0] drst_cnt_r;
  reg  [1:0] drst_cnt_nxt;
  wire       ref_stable;
  wire       exit_ready;

  // stable means the chosen reference is enabled and free of signal loss
  assign ref_stable = automode ? best_ok : ref_ok[manual_ref];
  // optional extra condition: wait for low phase error
  assign exit_ready = (exit_crit != CRIT_PHASE) || phase_err_low;

  // next state; switching only in preload or holdover in auto mode
  always @* begin
    state_nxt    = loop1_state_code_r;
    ref_nxt      = active_ref_r;
    div_nxt      = 1'b0;
    drst_cnt_nxt = drst_cnt_r;
    ld_restart   = 1'b0;
    case (loop1_state_code_r)
      ST_INIT: begin
        state_nxt = ST_PRELOAD;
      end
      ST_PRELOAD: begin
        ref_nxt   = automode ? best_ref : manual_ref;
        state_nxt = ST_ACQUIRE;
        ld_restart = 1'b1;
      end
      ST_ACQUIRE: begin
        if (!automode) begin
          ref_nxt = manual_ref;
        end
        if (!automode && force_ho) begin
          state_nxt = ST_HO_ENTRY;
        end else if (automode && !ref_ok[active_ref_r]) begin
          state_nxt = ST_HO_ENTRY;
        end else if (lock_raw) begin
          state_nxt = ST_LOCKED;
        end
      end
      ST_LOCKED: begin
        if (!automode) begin
          ref_nxt = manual_ref;
          if (force_ho) begin
            state_nxt = ST_HO_ENTRY;
          end else if (!lock_raw) begin
            state_nxt = ST_ACQUIRE;
          end
        end else if (!lock_raw || !ref_ok[active_ref_r] || prio_clash) begin
          state_nxt = ST_HO_ENTRY;
        end
      end
      ST_HO_ENTRY: begin
        state_nxt = ST_HO_HOLD;
      end
      ST_HO_HOLD: begin
        if (automode) begin
          ref_nxt = best_ref;
          if (ref_stable) begin
            state_nxt = ST_HO_EXIT;
          end
        end else begin
          ref_nxt = manual_ref;
          if (!force_ho && ref_stable) begin
            state_nxt = ST_HO_EXIT;
          end
        end
        drst_cnt_nxt = 2'h0;
      end
      ST_HO_EXIT: begin
        ld_restart = 1'b1;
        if (!ref_stable || (!automode && force_ho)) begin
          state_nxt = ST_HO_HOLD;
        end else if (exit_act != ACT_NO_RST &&
                     drst_cnt_r != `L1HO_DIV_RST_CYCLES) begin
          div_nxt      = 1'b1;
          drst_cnt_nxt = drst_cnt_r + 2'h1;
        end else if (exit_ready) begin
          state_nxt = ST_ACQUIRE;
        end
      end
      default: begin
        state_nxt = ST_INIT;
      end
    endcase
  end

  // state and output flops on the common multiple clock
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      loop1_state_code_r <= ST_INIT;
      active_ref_r       <= 2'h0;
      div_reset_r        <= 1'b0;
      drst_cnt_r         <= 2'h0;
    end else begin
      loop1_state_code_r <= state_nxt;
      active_ref_r       <= ref_nxt;
      div_reset_r        <= div_nxt;
      drst_cnt_r         <= drst_cnt_nxt;
    end
  end

  // ****************************************
  // holdover outputs
  // ****************************************
  wire in_ho_nxt;
  wire dac_hold;

  // pump tri-stated across all holdover sub-states
  assign in_ho_nxt = (state_nxt == ST_HO_ENTRY) || (state_nxt == ST_HO_HOLD) ||
                     (state_nxt == ST_HO_EXIT);
  // the assisted release keeps forcing the DAC through the exit phase
  assign dac_hold  = (state_nxt == ST_HO_ENTRY) || (state_nxt == ST_HO_HOLD) ||
                     ((state_nxt == ST_HO_EXIT) && (exit_act == ACT_DAC));

  // registered so the outputs change with the state code
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      charge_pump_tri_r <= 1'b0;
      dac_force_r       <= 1'b0;
      lock_detect_r     <= 1'b0;
    end else begin
      charge_pump_tri_r <= in_ho_nxt;
      dac_force_r       <= dac_hold && use_dac;
      lock_detect_r     <= lock_raw;
    end
  end

endmodule

`default_nettype wire

// ---- pkg/l1ho_defines.vh ----
// constants for the input-loop lock detect and holdover controller
`ifndef L1HO_DEFINES_VH
`define L1HO_DEFINES_VH

// ****************************************
// register offsets
// ****************************************
`define L1HO_OFS_REF_ENABLE  16'h0005
`define L1HO_OFS_PRIORITY    16'h0014
`define L1HO_OFS_EXIT_CFG    16'h0016
`define L1HO_OFS_LOCK_TIMER  16'h0028
`define L1HO_OFS_REF_SELECT  16'h0029
`define L1HO_OFS_STATE       16'h0082

// ****************************************
// field positions
// ****************************************
`define L1HO_SEL_MANUAL_LSB  0
`define L1HO_SEL_USE_DAC     2
`define L1HO_SEL_AUTOMODE    3
`define L1HO_SEL_FORCE_HO    4
`define L1HO_EXIT_CRIT_LSB   0
`define L1HO_EXIT_ACT_LSB    2
`define L1HO_ST_LOCK         3
`define L1HO_ST_REF_LSB      4
`define L1HO_ST_HOLDOVER     6

// ****************************************
// reset values
// ****************************************
`define L1HO_RST_LOCK_TIMER  8'h14
`define L1HO_RST_REF_SELECT  8'h00
`define L1HO_RST_EXIT_CFG    8'h05
`define L1HO_RST_PRIORITY    8'hE4
`define L1HO_RST_REF_ENABLE  8'h0F

// ****************************************
// timing
// ****************************************
`define L1HO_CMCLK_PERIOD_NS 40
`define L1HO_PHASE_THR_NS    4
`define L1HO_DIV_RST_CYCLES  2'h2

`endif

// ---- rtl/l1ho_lock_detect.v ----
// consecutive low-phase-error counter with lock output
`timescale 1ns/1ns
`default_nettype none

module l1ho_lock_detect #(
  parameter CNT_W = 32
) (
  input  wire             clk_sys,      // common multiple clock
  input  wire             arst_n,       // async reset, active low
  input  wire             restart,      // force count back to zero
  input  wire             err_low,      // phase error below threshold
  input  wire [4:0]       exponent,     // lock needs 2**exponent cycles
  output reg              lock_r        // lock indication
);

  reg  [CNT_W-1:0] cnt_r;
  wire [CNT_W-1:0] limit_m1;
  wire [CNT_W:0]   limit_full;

  // the limit minus one, so a count of 2**n cycles fits in CNT_W bits
  assign limit_full = {{CNT_W{1'b0}}, 1'b1} << exponent;
  assign limit_m1   = limit_full[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};

  // counter frozen once locked, saving toggling until an error arrives
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r  <= {CNT_W{1'b0}};
      lock_r <= 1'b0;
    end else if (restart || !err_low) begin
      cnt_r  <= {CNT_W{1'b0}};
      lock_r <= 1'b0;
    end else if (!lock_r) begin
      if (cnt_r == limit_m1) begin
        lock_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

`default_nettype wire

// ---- test/l1ho_ctrl_asserts.sv ----
// port-level assertions for the input-loop lock and holdover controller
`timescale 1ns/1ns
`default_nettype none

module l1ho_ctrl_asserts (
  input wire logic        clk_sys,            // common multiple clock
  input wire logic        arst_n,             // async reset, active low
  input wire logic        reg_wr,             // register write strobe
  input wire logic [15:0] reg_addr,           // register address
  input wire logic [7:0]  reg_wdata,          // register write data
  input wire logic        phase_err_low,      // low phase error
  input wire logic        lock_detect_r,      // lock indication
  input wire logic [1:0]  active_ref_r,       // reference in use
  input wire logic        charge_pump_tri_r,  // pump tri-stated
  input wire logic [2:0]  loop1_state_code_r  // state code
);
  logic       auto_r;
  logic       force_r;
  logic [2:0] st;

  assign st = loop1_state_code_r;

  // shadow of the mode bits, so manual-mode checks know the mode
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      auto_r  <= 1'b0;
      force_r <= 1'b0;
    end else if (reg_wr && reg_addr == 16'h0029) begin
      auto_r  <= reg_wdata[3];
      force_r <= reg_wdata[4];
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence acq_lock_s; st == 3'h2 ##1 st == 3'h3; endsequence
  sequence hold_leave_s; st == 3'h5 ##1 st != 3'h5; endsequence

  // ****************************************
  // properties
  // ****************************************
  reset_init_a: assert property (disable iff (1'b0)
    !arst_n |-> st == 3'h0) else $error("state left init in reset");
  preload_acq_a: assert property (st == 3'h1 |=> st == 3'h2)
    else $error("preload not followed by acquire");
  lock_enter_a: assert property (acq_lock_s |-> lock_detect_r)
    else $error("locked state without lock");
  lock_drop_a: assert property (!phase_err_low |-> ##2 !lock_detect_r)
    else $error("lock survived phase error");
  pump_tri_a: assert property (charge_pump_tri_r == (st >= 3'h4 && st <= 3'h6))
    else $error("pump tri-state wrong for state");
  entry_hold_a: assert property (st == 3'h4 |=> st == 3'h5)
    else $error("entry not followed by steady holdover");
  hold_exit_a: assert property (hold_leave_s |-> st == 3'h6)
    else $error("holdover left without exit state");
  exit_path_a: assert property (st == 3'h6 |=> st == 3'h6 || st == 3'h5 || st == 3'h2)
    else $error("bad state after holdover exit");
  auto_switch_a: assert property (auto_r && $changed(active_ref_r) |->
    $past(st) == 3'h1 || $past(st) == 3'h5) else $error("reference switched outside window");
  manual_hold_a: assert property (!auto_r && !force_r && !reg_wr && st == 3'h3
    |=> st == 3'h3 || st == 3'h2) else $error("evasive action in manual mode");
endmodule

`default_nettype wire

// ---- test/tb.sv ----
// testbench for the input-loop lock and holdover controller
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic        clk_sys = 0;
  logic        arst_n = 1;
  logic        reg_wr = 0;
  logic        reg_rd = 0;
  logic [15:0] reg_addr = 0;
  logic [7:0]  reg_wdata = 0;
  logic [3:0]  lf = 0;
  logic        pel = 0;
  wire  [7:0]  rdata;
  wire         lock;
  wire  [1:0]  aref;
  wire         pump_tri;
  wire         dac;
  wire         divr;
  wire  [2:0]  st;
  int          errors = 0;
  int          checks_done = 0;

  l1ho_ctrl #(.CNT_W(32), .NUM_REF(4)) u_l1ho_ctrl (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_r(rdata), .signal_loss_flag(lf), .phase_err_low(pel),
    .lock_detect_r(lock), .active_ref_r(aref), .charge_pump_tri_r(pump_tri),
    .dac_force_r(dac), .div_reset_r(divr), .loop1_state_code_r(st));

  // 25 MHz clock
  always #20 clk_sys = ~clk_sys;

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 0;
  endtask
  // read data is registered at the strobe edge, sampled one half cycle on
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    reg_rd = 1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 0;
    chk("rdata", e, rdata);
  endtask
  // bounded wait so a stuck machine cannot hang the run
  task automatic wait_st(input logic [2:0] e);
    for (int i = 0; i < 40 && st !== e; i++) step(1);
    chk("state", {5'h0, e}, {5'h0, st});
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // reset falls just after time zero so the asynchronous branch sees a real edge
  task automatic t_reset;
    #1;
    arst_n = 0;
    step(12);
    chk("state", 8'h00, {5'h0, st});
    arst_n = 1;
    step(1);
    chk("state", 8'h01, {5'h0, st});
    step(1);
    chk("state", 8'h02, {5'h0, st});
    rd(16'h0028, 8'h14);
    rd(16'h0029, 8'h00);
    rd(16'h0100, 8'h00);
    rd(16'h0082, 8'h02);
    $display("t_reset done");
  endtask

  task automatic t_lock;
    wr(16'h0028, 8'h02);
    pel = 1;
    step(3);
    pel = 0;
    step(1);
    pel = 1;
    step(4);
    chk("lock", 8'h00, {7'h0, lock});
    step(1);
    chk("lock", 8'h01, {7'h0, lock});
    chk("state", 8'h03, {5'h0, st});
    rd(16'h0082, 8'h0B);
    $display("t_lock done");
  endtask

  task automatic t_manual;
    lf = 4'b0001;
    step(6);
    chk("state", 8'h03, {5'h0, st});
    lf = 0;
    wr(16'h0029, 8'h10);
    wait_st(3'h4);
    chk("pump_tri", 8'h01, {7'h0, pump_tri});
    chk("dac", 8'h00, {7'h0, dac});
    wr(16'h0029, 8'h01);
    wait_st(3'h3);
    chk("aref", 8'h01, {6'h0, aref});
    wr(16'h0029, 8'h00);
    step(1);
    wait_st(3'h3);
    chk("aref", 8'h00, {6'h0, aref});
    $display("t_manual done");
  endtask

  task automatic t_auto;
    int n;
    n = 0;
    wr(16'h0029, 8'h0C);
    lf = 4'b0001;
    step(1);
    chk("state", 8'h04, {5'h0, st});
    chk("pump_tri", 8'h01, {7'h0, pump_tri});
    chk("dac", 8'h01, {7'h0, dac});
    step(1);
    chk("state", 8'h05, {5'h0, st});
    wait_st(3'h3);
    chk("aref", 8'h01, {6'h0, aref});
    wr(16'h0016, 8'h00);
    pel = 0;
    step(1);
    pel = 1;
    wait_st(3'h4);
    for (int i = 0; i < 30; i++) begin
      step(1);
      n += divr;
    end
    chk("div_reset", 8'h02, n[7:0]);
    chk("state", 8'h03, {5'h0, st});
    lf = 0;
    $display("t_auto done");
  endtask

  // assisted release keeps the dac forcing; priority and enable steer the choice
  task automatic t_dac;
    wr(16'h0016, 8'h0C);
    wait_st(3'h6);
    chk("dac", 8'h01, {7'h0, dac});
    wait_st(3'h3);
    chk("aref", 8'h00, {6'h0, aref});
    wr(16'h0014, 8'h1B);
    wait_st(3'h5);
    wait_st(3'h3);
    chk("aref", 8'h03, {6'h0, aref});
    wr(16'h0005, 8'h07);
    wait_st(3'h5);
    wait_st(3'h3);
    chk("aref", 8'h02, {6'h0, aref});
    rd(16'h0014, 8'h1B);
    rd(16'h0005, 8'h07);
    $display("t_dac done");
  endtask

  // reset in mid-run returns the select and exit settings and the machine to the start
  task automatic t_rst2;
    arst_n = 0;
    step(2);
    chk("state", 8'h00, {5'h0, st});
    chk("pump_tri", 8'h00, {7'h0, pump_tri});
    chk("aref", 8'h00, {6'h0, aref});
    arst_n = 1;
    step(1);
    chk("state", 8'h01, {5'h0, st});
    step(1);
    chk("state", 8'h02, {5'h0, st});
    rd(16'h0029, 8'h00);
    rd(16'h0016, 8'h05);
    $display("t_rst2 done");
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // main sequence
  initial begin
    t_reset();
    t_lock();
    t_manual();
    t_auto();
    t_dac();
    t_rst2();
    conclude();
  end

  // watchdog: a few hundred cycles expected, allow far more
  initial begin
    #(40 * 4000);
    errors++;
    conclude();
  end
endmodule

bind l1ho_ctrl l1ho_ctrl_asserts u_l1ho_ctrl_asserts (.clk_sys(clk_sys), .arst_n(arst_n),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .phase_err_low(phase_err_low), .lock_detect_r(lock_detect_r),
  .active_ref_r(active_ref_r), .charge_pump_tri_r(charge_pump_tri_r),
  .loop1_state_code_r(loop1_state_code_r));

`default_nettype wire
